// ### hdl/fcsc_pkg.sv
package fcsc_pkg;
  // -----------------------------------------
  // Register map
  // -----------------------------------------
  localparam logic [7:0] ADDR_SCALER   = 8'h00;
  localparam logic [7:0] ADDR_OPTIONS  = 8'h04;
  localparam logic [7:0] ADDR_CONFIG   = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;
  localparam logic [2:0] KEY_WIN_PAGE  = 3'h1;
  localparam int         KEY_BYTES     = 8;
  localparam logic [7:0] SCALER_RST    = 8'h00;
  localparam int         CFG_KEY_ACCESS_BIT    = 5;
  localparam int         STS_ACCERR    = 4;
  localparam int         STS_PGMEN     = 1;
  localparam int         STS_SECURE    = 0;
  localparam logic [1:0] SEC_UNSECURED = 2'b10;
  localparam logic [1:0] RESP_OKAY     = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;
  // -----------------------------------------
  // Timing
  // -----------------------------------------
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         FCLK_MIN_KHZ  = 150;
  localparam int         FCLK_MAX_KHZ  = 200;
  localparam int         PRESCALE_DIV  = 8;
  localparam logic [2:0] PRESCALE_LAST = 3'(PRESCALE_DIV - 1);
  // Shortest legal timing-clock period, in bus cycles
  localparam int FCLK_MIN_CYC = 1000000 / (FCLK_MAX_KHZ * CLK_PERIOD_NS);
  // -----------------------------------------
  // Types
  // -----------------------------------------
  typedef struct packed {
    logic       written;
    logic       pre8;
    logic [5:0] ratio;
  } fcsc_scaler_t;
  typedef struct packed {
    logic       key_en;
    logic       redir_dis;
    logic [3:0] rsv;
    logic [1:0] sec;
  } fcsc_opts_t;
  typedef enum logic [1:0] {KEY_OFF, KEY_COLLECT, KEY_FAILED} fcsc_key_st_t;

  function automatic logic fcsc_is_secure(input logic [1:0] sec);
    return sec != SEC_UNSECURED;
  endfunction

  function automatic logic [9:0] fcsc_period(input fcsc_scaler_t s);
    return (s.pre8 ? 10'(PRESCALE_DIV) : 10'h001) * (10'(s.ratio) + 10'h001);
  endfunction
endpackage

// ### hdl/fcsc_top.sv
`timescale 1ns/100ps
// Function
// R1: Scaler top bit read-only; low seven bits writable only once after reset.
// R2: Written flag clears on reset, sets on first scaler write, any data.
// R3: Program and erase disabled until the written flag is one.
// R4: Scaler input is bus clock, or bus clock over eight when prescale set.
// R5: Timing clock is scaler input divided by ratio plus one.
// R6: Software keeps the timing clock between 150 kHz and 200 kHz.
// R7: Each timing pulse is one timing-clock period; operations use whole pulses.
// R8: Options loaded from stored byte during reset; changes only on new reset (here, unlock and blank pass also set the security code to 1:0).
// R9: Options and protection copied at reset; eight-byte key held in flash.
// R10: Key-enable zero means backdoor key can never lift security.
// R11: Key bytes accepted only from secure firmware, never from debug commands.
// R12: Eight matching key bytes in order lift security until next reset.
// R13: Redirection-disable one disables vector redirection; zero enables it.
// R14: Only security code 1:0 is unsecured; all other codes secure.
// R15: While secure, block memory access from unsecured sources and debug.
// R16: Security code becomes 1:0 after key unlock or whole-flash blank pass.
// R17: Key-access zero: window writes start commands; one: comparison key writes.
// R18: Firmware sets key access, writes eight bytes ascending, then clears it.
// R19: Command before scaler written flags access error and is ignored.
// R20: Timing clock is a one-cycle enable from a reloadable down-counter.
module fcsc_top
  import fcsc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  stored_options_byte,
  input  wire logic [7:0]  stored_protection_byte,
  input  wire logic [63:0] stored_backdoor_key,
  input  wire logic        blank_check_pass,
  output logic [7:0]       working_protection_reg,
  output logic             flash_clk_en,
  output logic             erase_program_enable,
  output logic             secure,
  output logic             block_unsecured_access,
  output logic             redirection_enable,
  output logic             cmd_start,
  output logic [2:0]       cmd_offset,
  output logic [7:0]       cmd_data
);
  // ---------------------------------------------
  // State
  // ---------------------------------------------
  fcsc_scaler_t scaler_q, scaler_d;
  fcsc_opts_t   opts_q, opts_d;
  fcsc_key_st_t key_st_q, key_st_d;
  logic [7:0]   prot_q, prot_d;
  logic         key_access_bit_q, key_access_bit_d;
  logic         accerr_q, accerr_d;
  logic [3:0]   key_idx_q, key_idx_d;
  logic [2:0]   pre_cnt_q, pre_cnt_d;
  logic [5:0]   div_cnt_q, div_cnt_d;
  logic         fclk_q, fclk_d;
  logic         cmd_q, cmd_d;
  logic [2:0]   cmd_off_q, cmd_off_d;
  logic [7:0]   cmd_dat_q, cmd_dat_d;
  logic         aw_have_q, aw_have_d;
  logic         w_have_q, w_have_d;
  logic [7:0]   waddr_q, waddr_d;
  logic         wdbg_q, wdbg_d;
  logic [7:0]   wbyte_q, wbyte_d;
  logic         wlane_q, wlane_d;
  logic         bvalid_q, bvalid_d;
  logic [1:0]   bresp_q, bresp_d;
  logic         rvalid_q, rvalid_d;
  logic [31:0]  rdata_q, rdata_d;
  logic [1:0]   rresp_q, rresp_d;
  logic         wr_go, pre_en, key_hit, key_wr, cmd_wr, key_close, unlock;
  logic [7:0]   key_byte, rd_byte;

  assign s_axi_awready          = !aw_have_q && !bvalid_q;
  assign s_axi_wready           = !w_have_q && !bvalid_q;
  assign s_axi_arready          = !rvalid_q;
  assign s_axi_bvalid           = bvalid_q;
  assign s_axi_bresp            = bresp_q;
  assign s_axi_rvalid           = rvalid_q;
  assign s_axi_rdata            = rdata_q;
  assign s_axi_rresp            = rresp_q;
  assign working_protection_reg = prot_q;
  assign flash_clk_en           = fclk_q;
  assign erase_program_enable   = scaler_q.written;              // R3
  assign secure                 = fcsc_is_secure(opts_q.sec);    // R14
  assign block_unsecured_access = secure;                        // R15
  assign redirection_enable     = !opts_q.redir_dis;             // R13
  assign cmd_start              = cmd_q;
  assign cmd_offset             = cmd_off_q;
  assign cmd_data               = cmd_dat_q;

  // ---------------------------------------------
  // Write decode
  // ---------------------------------------------
  assign wr_go     = aw_have_q && w_have_q && !bvalid_q;
  assign key_hit   = waddr_q[7:5] == KEY_WIN_PAGE;
  assign key_byte  = stored_backdoor_key[8*key_idx_q[2:0] +: 8];
  assign key_wr    = wr_go && wlane_q && key_hit && key_access_bit_q && !wdbg_q;    // R11
  assign cmd_wr    = wr_go && wlane_q && key_hit && !key_access_bit_q;              // R17
  assign key_close = wr_go && wlane_q && waddr_q == ADDR_CONFIG && key_access_bit_q
                     && !wbyte_q[CFG_KEY_ACCESS_BIT];
  assign unlock    = key_close && opts_q.key_en && key_st_q == KEY_COLLECT
                     && key_idx_q == 4'(KEY_BYTES);                         // R10 R12
  assign pre_en    = !scaler_q.pre8 || pre_cnt_q == PRESCALE_LAST;          // R4

  always_comb begin
    case (s_axi_araddr)
      ADDR_SCALER:  rd_byte = scaler_q;
      ADDR_OPTIONS: rd_byte = opts_q;
      ADDR_CONFIG:  rd_byte = {2'h0, key_access_bit_q, 5'h00};
      ADDR_STATUS:  rd_byte = {3'h0, accerr_q, 2'h0, scaler_q.written, secure};
      default:      rd_byte = 8'h00;
    endcase
  end

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb begin
    scaler_d  = scaler_q;
    opts_d    = opts_q;
    prot_d    = prot_q;
    key_access_bit_d  = key_access_bit_q;
    accerr_d  = accerr_q;
    key_st_d  = key_st_q;
    key_idx_d = key_idx_q;
    cmd_d     = 1'b0;
    cmd_off_d = cmd_off_q;
    cmd_dat_d = cmd_dat_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    waddr_d   = waddr_q;
    wdbg_d    = wdbg_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    pre_cnt_d = scaler_q.pre8 ? pre_cnt_q + 3'h1 : 3'h0;
    div_cnt_d = div_cnt_q;
    fclk_d    = 1'b0;
    // Timing clock enable
    if (!scaler_q.written) begin
      div_cnt_d = scaler_q.ratio;
    end else if (pre_en) begin
      if (div_cnt_q == 6'h00) begin
        div_cnt_d = scaler_q.ratio;                                         // R5 R20
        fclk_d    = 1'b1;                                                   // R7
      end else begin
        div_cnt_d = div_cnt_q - 6'h01;
      end
    end
    // Bus channels
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      waddr_d   = s_axi_awaddr;
      wdbg_d    = s_axi_awprot[1];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wbyte_d  = s_axi_wdata[7:0];
      wlane_d  = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = {24'h000000, rd_byte};
      rresp_d  = (s_axi_araddr <= ADDR_STATUS && s_axi_araddr[1:0] == 2'h0)
                 ? RESP_OKAY : RESP_SLVERR;
    end
    // Register writes
    if (wr_go) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (key_hit || (waddr_q <= ADDR_STATUS && waddr_q[1:0] == 2'h0))
                  ? RESP_OKAY : RESP_SLVERR;
      if (wlane_q && waddr_q == ADDR_SCALER && !scaler_q.written) begin
        scaler_d = {1'b1, wbyte_q[6:0]};                                    // R1 R2
      end
      if (wlane_q && waddr_q == ADDR_STATUS && wbyte_q[STS_ACCERR]) begin
        accerr_d = 1'b0;
      end
      if (wlane_q && waddr_q == ADDR_CONFIG) begin
        key_access_bit_d = wbyte_q[CFG_KEY_ACCESS_BIT];
        if (wbyte_q[CFG_KEY_ACCESS_BIT] && !key_access_bit_q) begin
          key_st_d  = KEY_COLLECT;
          key_idx_d = 4'h0;
        end
      end
    end
    // Key comparison
    if (key_wr) begin
      case (key_st_q)
        KEY_COLLECT: begin
          if (waddr_q[4:2] == key_idx_q[2:0] && key_idx_q < 4'(KEY_BYTES)
              && wbyte_q == key_byte) begin
            key_idx_d = key_idx_q + 4'h1;                                   // R12
          end else begin
            key_st_d = KEY_FAILED;
          end
        end
        default: key_st_d = key_st_q;
      endcase
    end
    if (key_close) begin
      key_st_d = KEY_OFF;
    end
    // Command path
    if (cmd_wr) begin
      if (scaler_q.written) begin
        cmd_d     = 1'b1;                                                   // R3
        cmd_off_d = waddr_q[4:2];
        cmd_dat_d = wbyte_q;
      end else begin
        accerr_d = 1'b1;                                                    // R19
      end
    end
    if (unlock || blank_check_pass) begin
      opts_d.sec = SEC_UNSECURED;                                           // R16
    end
  end

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scaler_q  <= SCALER_RST;
      opts_q    <= stored_options_byte;                                     // R8 R9
      prot_q    <= stored_protection_byte;                                  // R9
      key_access_bit_q  <= 1'b0;
      accerr_q  <= 1'b0;
      key_st_q  <= KEY_OFF;
      key_idx_q <= 4'h0;
      pre_cnt_q <= 3'h0;
      div_cnt_q <= 6'h00;
      fclk_q    <= 1'b0;
      cmd_q     <= 1'b0;
      cmd_off_q <= 3'h0;
      cmd_dat_q <= 8'h00;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      waddr_q   <= 8'h00;
      wdbg_q    <= 1'b0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else begin
      scaler_q  <= scaler_d;
      opts_q    <= opts_d;
      prot_q    <= prot_d;
      key_access_bit_q  <= key_access_bit_d;
      accerr_q  <= accerr_d;
      key_st_q  <= key_st_d;
      key_idx_q <= key_idx_d;
      pre_cnt_q <= pre_cnt_d;
      div_cnt_q <= div_cnt_d;
      fclk_q    <= fclk_d;
      cmd_q     <= cmd_d;
      cmd_off_q <= cmd_off_d;
      cmd_dat_q <= cmd_dat_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      waddr_q   <= waddr_d;
      wdbg_q    <= wdbg_d;
      wbyte_q   <= wbyte_d;
      wlane_q   <= wlane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  logic [9:0] gap_q;
  logic       seen_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q  <= 10'h000;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= fclk_q ? 10'h001 : gap_q + 10'h001;
      seen_q <= seen_q || fclk_q;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence key_entry_done;
    key_st_q == KEY_COLLECT && key_idx_q == 4'(KEY_BYTES) && opts_q.key_en;
  endsequence
  sequence key_clear_write;
    key_close ##1 !key_access_bit_q;
  endsequence

  scaler_once_a: assert property (scaler_q.written && wr_go |=> $stable(scaler_q)) // R1
    else $error("scaler changed after first write");
  flag_set_a: assert property (!scaler_q.written && wr_go && wlane_q
      && waddr_q == ADDR_SCALER |=> scaler_q.written && scaler_q.ratio == $past(wbyte_q[5:0])) // R2
    else $error("scaler write did not set flag");
  cmd_gate_a: assert property (cmd_q |-> $past(scaler_q.written)) // R3
    else $error("command issued before scaler written");
  prescale_off_a: assert property (scaler_q.written && !scaler_q.pre8 |-> pre_en) // R4
    else $error("prescale active with bit clear");
  fclk_period_a: assert property (fclk_q && seen_q |-> gap_q == fcsc_period(scaler_q)) // R5
    else $error("timing pulse spacing wrong");
  key_off_a: assert property ($fell(secure) && !$past(blank_check_pass)
      |-> $past(opts_q.key_en)) // R10
    else $error("unlock while key disabled");
  debug_key_a: assert property (wr_go && wlane_q && key_hit && key_access_bit_q && wdbg_q
      |=> $stable(key_idx_q) && $stable(key_st_q)) // R11
    else $error("debug write reached key compare");
  unlock_seq_a: assert property (key_entry_done and key_close |=> !secure ##1 !secure) // R12
    else $error("matching key did not unlock");
  key_path_a: assert property (key_hit && wr_go && key_access_bit_q |=> !cmd_q) // R17
    else $error("key write started a command");
  acc_err_a: assert property (cmd_wr && !scaler_q.written |=> accerr_q && !cmd_q) // R19
    else $error("early command not flagged");
  close_ends_a: assert property (key_clear_write |-> key_st_q == KEY_OFF) // R18
    else $error("key entry not closed");
  blank_pass_a: assert property (blank_check_pass |=> !secure) // R16
    else $error("blank pass left part secure");
endmodule

// ### verification/tb.sv
`timescale 1ns/100ps
module tb;
  import fcsc_pkg::*;
  // -----------------------------------------
  // Signals
  // -----------------------------------------
  localparam logic [63:0] KEY = 64'h0f1e2d3c4b5a6978;
  localparam logic [7:0]  KACC = 8'(1 << CFG_KEY_ACCESS_BIT);
  logic        aclk, aresetn, blank_check_pass;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, stored_options_byte, stored_protection_byte;
  logic [2:0]  s_axi_awprot, s_axi_arprot, cmd_offset;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, flash_clk_en, erase_program_enable;
  logic        secure, block_unsecured_access, redirection_enable, cmd_start;
  logic [63:0] stored_backdoor_key;
  logic [7:0]  working_protection_reg, cmd_data;
  logic [10:0] cmd_last;
  int          n_errors, n_tests, n_cmd, cyc;

  fcsc_top u_fcsc_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .stored_options_byte, .stored_protection_byte, .stored_backdoor_key,
    .blank_check_pass, .working_protection_reg, .flash_clk_en, .erase_program_enable,
    .secure, .block_unsecured_access, .redirection_enable, .cmd_start, .cmd_offset,
    .cmd_data
  );

  // -----------------------------------------
  // Clock, timeout, command monitor
  // -----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(negedge aclk) begin
    cyc++;
    if (cmd_start === 1'b1) begin
      n_cmd++;
      cmd_last = {cmd_offset, cmd_data};
    end
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end

  // -----------------------------------------
  // Tasks
  // -----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [2:0] p = 3'h0);
    logic aw_ok, w_ok, aw_hs, w_hs, b_hs;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_hs = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awprot <= p;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = !aw_ok && s_axi_awready === 1'b1;
      w_hs = !w_ok && s_axi_wready === 1'b1;
      b_hs = aw_ok && w_ok && s_axi_bvalid === 1'b1;
      if (b_hs)
        resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (w_hs) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar_hs, r_hs;
    ar_hs = 1'b0;
    r_hs = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!ar_hs) begin
      @(negedge aclk);
      ar_hs = s_axi_arready === 1'b1;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    while (!r_hs) begin
      @(negedge aclk);
      r_hs = s_axi_rvalid === 1'b1;
      if (r_hs) begin
        rv = s_axi_rdata;
        resp = s_axi_rresp;
      end
      @(posedge aclk);
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic rst(input logic [7:0] opt);
    @(posedge aclk);
    aresetn <= 1'b0;
    stored_options_byte <= opt;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic key_try(input logic [2:0] p, input int bad);
    wr(ADDR_CONFIG, KACC);
    for (int i = 0; i < KEY_BYTES; i++) begin
      wr(8'h20 + 8'(4 * i), KEY[8*i +: 8] ^ ((i == bad) ? 8'hff : 8'h00), p);
    end
    wr(ADDR_CONFIG, 8'h00);
    repeat (2) @(posedge aclk);
  endtask

  task automatic per(input int exp, input string msg);
    int n;
    n = 0;
    do @(negedge aclk); while (flash_clk_en !== 1'b1);
    do begin
      @(negedge aclk);
      n++;
    end while (flash_clk_en !== 1'b1 && n < 2000);
    chk(32'(n), 32'(exp), msg);
  endtask

  task automatic conclude();
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // -----------------------------------------
  // Sequence
  // -----------------------------------------
  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, blank_check_pass} = '0;
    {n_errors, n_tests, n_cmd, cyc} = '0;
    s_axi_arprot = 3'h0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    stored_options_byte = 8'h83;
    stored_protection_byte = 8'hf8;
    stored_backdoor_key = KEY;
    rst(8'h83);
    rd(ADDR_OPTIONS);
    chk(rv, 32'h83, "options load");
    chk(32'(working_protection_reg), 32'hf8, "protection copy");
    chk(32'({secure, block_unsecured_access}), 32'h3, "secure code 11");
    chk(32'(redirection_enable), 32'h1, "redirection on");
    stored_options_byte <= 8'h40;
    rd(ADDR_OPTIONS);
    chk(rv, 32'h83, "options hold");
    rd(ADDR_SCALER);
    chk(rv, 32'(SCALER_RST), "scaler reset");
    chk(32'(erase_program_enable), 32'h0, "pe before write");
    wr(8'h20, 8'h5a);
    rd(ADDR_STATUS);
    chk(rv & 32'h12, 32'h10, "early command error");
    chk(32'(n_cmd), 32'h0, "early command ignored");
    wr(ADDR_STATUS, 8'h10);
    rd(ADDR_STATUS);
    chk(rv & 32'h10, 32'h0, "error cleared");
    wr(ADDR_SCALER, 8'h7e);
    rd(ADDR_SCALER);
    chk(rv, 32'hfe, "scaler first write");
    chk(32'(erase_program_enable), 32'h1, "pe after write");
    wr(ADDR_SCALER, 8'h05);
    rd(ADDR_SCALER);
    chk(rv, 32'hfe, "scaler second write");
    per(PRESCALE_DIV * 63, "prescaled period");
    wr(8'h2c, 8'ha5);
    repeat (2) @(posedge aclk);
    chk(32'(n_cmd), 32'h1, "window command");
    chk(32'(cmd_last), {21'h0, 3'h3, 8'ha5}, "command offset data");
    key_try(3'b010, -1);
    chk(32'(secure), 32'h1, "debug key ignored");
    key_try(3'b000, 7);
    chk(32'(secure), 32'h1, "wrong key");
    key_try(3'b000, -1);
    chk(32'({secure, block_unsecured_access}), 32'h0, "key unlock");
    chk(32'(n_cmd), 32'h1, "key writes no command");
    rd(ADDR_OPTIONS);
    chk(rv, 32'h82, "options after unlock");
    rd(ADDR_STATUS);
    chk(rv & 32'h01, 32'h0, "status unsecured");
    rd(8'h14);
    chk(32'(resp), 32'(RESP_SLVERR), "unmapped read");
    wr(8'h14, 8'h01);
    chk(32'(resp), 32'(RESP_SLVERR), "unmapped write");
    rst(8'h43);
    chk(32'(redirection_enable), 32'h0, "redirection off");
    rd(ADDR_SCALER);
    chk(rv, 32'(SCALER_RST), "scaler cleared by reset");
    wr(ADDR_SCALER, 8'h03);
    per(4, "direct period");
    key_try(3'b000, -1);
    chk(32'(secure), 32'h1, "key disabled");
    @(posedge aclk);
    blank_check_pass <= 1'b1;
    @(posedge aclk);
    blank_check_pass <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(secure), 32'h0, "blank check unlock");
    for (int c = 0; c < 4; c++) begin
      rst(8'(c));
      chk(32'(secure), (c == 2) ? 32'h0 : 32'h1, "security decode");
    end
    conclude();
  end
endmodule
